// ===== logic/bsreu_defs.svh
// constants for the bit set, reset and encode unit
`ifndef BSREU_DEFS_SVH
`define BSREU_DEFS_SVH

`define BSREU_ADDR_W 5
`define BSREU_WORD_W 16
`define BSREU_WORDS 16
`define BSREU_TBL_W 256
`define BSREU_FLAGS_ADDR 5'h10
`define BSREU_INT_STAT_ADDR 5'h11
`define BSREU_INT_MASK_ADDR 5'h12
`define BSREU_CARRY_BIT 0
`define BSREU_ERROR_BIT 1
`define BSREU_EV_DONE_BIT 0
`define BSREU_EV_ERR_BIT 1
`define BSREU_ALL_ONES 16'hFFFF
`define BSREU_ALL_ZERO 16'h0000
`define BSREU_WORD_RST 16'h0000
`define BSREU_EV_RST 2'h0
`define BSREU_N_MIN 4'h1
`define BSREU_N_MAX 4'h8

`endif

// ===== logic/bsreu_pkg.sv
// types shared by the bit set, reset and encode unit
package bsreu_pkg;

    typedef enum logic [2:0] {
        BSREU_OP_FILL = 3'h0,
        BSREU_OP_CLEAR = 3'h1,
        BSREU_OP_CARRY_SET = 3'h2,
        BSREU_OP_CARRY_CLEAR = 3'h3,
        BSREU_OP_PRIORITY_FIND = 3'h4,
        BSREU_OP_ONE_HOT_EXPAND = 3'h5,
        BSREU_OP_ONES_TALLY = 3'h6
    } bsreu_op_t;

    // one instruction as issued by the scan engine
    typedef struct packed {
        bsreu_op_t op;
        logic enable;
        logic bit_mode;
        logic [3:0] dst_word;
        logic [3:0] dst_bit;
        logic [3:0] src_word;
        logic [3:0] size_n;
    } bsreu_instr_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bsreu_bus_req_t;

endpackage

// ===== logic/bsreu_tally.sv
// counts the one bits of a word
`timescale 1ns/1ns
module bsreu_tally (
    input wire logic [15:0] word_in,
    output logic [4:0] count_out
);
    logic [4:0] part [17];

    assign part[0] = 5'h00;
    genvar b;
    generate
        for (b = 0; b < 16; b++) begin : g_sum
            assign part[b + 1] = part[b] + {4'h0, word_in[b]};
        end
    endgenerate
    assign count_out = part[16];
endmodule

// ===== logic/bsreu_top.sv
// bit set, reset, encode, decode and tally unit with its word store
// Notes on behaviour
// - disabled: no operation, output false
// - fill on a bit sets it
// - fill on a word writes all ones
// - word write covers its sixteen bits
// - written values persist until next write
// - clear on a bit zeroes it
// - clear on a word writes zero
// - carry set drives carry to one
// - carry clear drives carry to zero
// - priority find stores highest set bit position
// - tables continue into following words
// - empty table: no write, output false, error
// - expand sets indexed bit, clears others
// - tally counts one bits of source
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "bsreu_defs.svh"
module bsreu_top #(
    parameter bit TALLY_EN = 1'b1
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire bsreu_pkg::bsreu_bus_req_t bus_in,
    output logic [15:0] bus_rdata_out,
    input wire logic instr_valid_in,
    input wire bsreu_pkg::bsreu_instr_t instr_in,
    output logic rung_out,
    output logic done_out,
    output logic carry_flag_out,
    output logic instruction_error_flag_out,
    output logic irq_out
);
    logic [15:0] mem_r [`BSREU_WORDS];
    logic [15:0] mem_nxt [`BSREU_WORDS];
    logic carry_r;
    logic carry_nxt;
    logic err_r;
    logic err_nxt;
    logic rung_r;
    logic rung_nxt;
    logic done_r;
    logic done_nxt;
    logic [1:0] stat_r;
    logic [1:0] stat_nxt;
    logic [1:0] mask_r;
    logic [1:0] mask_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    logic [`BSREU_TBL_W-1:0] src_tbl;
    logic [8:0] tbl_len;
    logic size_bad;
    logic found;
    logic [7:0] find_pos;
    logic [7:0] exp_idx;
    logic [4:0] tally_cnt;
    logic exec;
    logic fail;
    logic table_op;

    // tables wrap past the last word back to word 0
    genvar i;
    generate
        for (i = 0; i < `BSREU_WORDS; i++) begin : g_tbl
            assign src_tbl[i*16 +: 16] = mem_r[4'(instr_in.src_word + 4'(i))];
        end
    endgenerate

    assign tbl_len = 9'h001 << instr_in.size_n;
    assign table_op = (instr_in.op == bsreu_pkg::BSREU_OP_PRIORITY_FIND)
        || (instr_in.op == bsreu_pkg::BSREU_OP_ONE_HOT_EXPAND);
    assign size_bad = table_op && ((instr_in.size_n < `BSREU_N_MIN)
        || (instr_in.size_n > `BSREU_N_MAX));
    assign exp_idx = mem_r[instr_in.src_word][7:0] & 8'(tbl_len - 9'h001);

    // last hit wins, so the highest set bit is kept
    always_comb begin
        found = 1'b0;
        find_pos = 8'h00;
        for (int k = 0; k < `BSREU_TBL_W; k++) begin
            if (src_tbl[k] && (9'(k) < tbl_len)) begin
                found = 1'b1;
                find_pos = 8'(k);
            end
        end
    end

    bsreu_tally u_tally (
        .word_in(mem_r[instr_in.src_word]),
        .count_out(tally_cnt)
    );

    assign exec = instr_valid_in && instr_in.enable;
    assign fail = exec && (size_bad
        || ((instr_in.op == bsreu_pkg::BSREU_OP_PRIORITY_FIND) && !found)
        || ((instr_in.op == bsreu_pkg::BSREU_OP_ONES_TALLY) && !TALLY_EN));

    always_comb begin
        mem_nxt = mem_r;
        carry_nxt = carry_r;
        err_nxt = err_r;
        rung_nxt = rung_r;
        done_nxt = 1'b0;
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        rdata_nxt = `BSREU_ALL_ZERO;
        if (bus_in.wr) begin
            if (bus_in.addr < `BSREU_FLAGS_ADDR) begin
                mem_nxt[bus_in.addr[3:0]] = bus_in.wdata;
            end else begin
                case (bus_in.addr)
                    `BSREU_FLAGS_ADDR: begin
                        carry_nxt = bus_in.wdata[`BSREU_CARRY_BIT];
                        if (bus_in.wdata[`BSREU_ERROR_BIT]) begin
                            err_nxt = 1'b0;
                        end
                    end
                    `BSREU_INT_STAT_ADDR: stat_nxt = stat_r & ~bus_in.wdata[1:0];
                    `BSREU_INT_MASK_ADDR: mask_nxt = bus_in.wdata[1:0];
                    default: ;
                endcase
            end
        end
        if (bus_in.rd) begin
            if (bus_in.addr < `BSREU_FLAGS_ADDR) begin
                rdata_nxt = mem_r[bus_in.addr[3:0]];
            end else begin
                case (bus_in.addr)
                    `BSREU_FLAGS_ADDR: rdata_nxt = {14'h0, err_r, carry_r};
                    `BSREU_INT_STAT_ADDR: rdata_nxt = {14'h0, stat_r};
                    `BSREU_INT_MASK_ADDR: rdata_nxt = {14'h0, mask_r};
                    default: rdata_nxt = `BSREU_ALL_ZERO;
                endcase
            end
        end
        // instruction applied after the bus so it wins a same-cycle clash,
        // and hardware sets beat software clears
        if (instr_valid_in) begin
            done_nxt = 1'b1;
            rung_nxt = exec && !fail;
            if (fail) begin
                err_nxt = 1'b1;
                stat_nxt[`BSREU_EV_ERR_BIT] = 1'b1;
            end else if (exec) begin
                stat_nxt[`BSREU_EV_DONE_BIT] = 1'b1;
                case (instr_in.op)
                    bsreu_pkg::BSREU_OP_FILL: begin
                        if (instr_in.bit_mode) begin
                            mem_nxt[instr_in.dst_word][instr_in.dst_bit] = 1'b1;
                        end else begin
                            mem_nxt[instr_in.dst_word] = `BSREU_ALL_ONES;
                        end
                    end
                    bsreu_pkg::BSREU_OP_CLEAR: begin
                        if (instr_in.bit_mode) begin
                            mem_nxt[instr_in.dst_word][instr_in.dst_bit] = 1'b0;
                        end else begin
                            mem_nxt[instr_in.dst_word] = `BSREU_ALL_ZERO;
                        end
                    end
                    bsreu_pkg::BSREU_OP_CARRY_SET: carry_nxt = 1'b1;
                    bsreu_pkg::BSREU_OP_CARRY_CLEAR: carry_nxt = 1'b0;
                    bsreu_pkg::BSREU_OP_PRIORITY_FIND: begin
                        mem_nxt[instr_in.dst_word] = {8'h00, find_pos};
                    end
                    bsreu_pkg::BSREU_OP_ONE_HOT_EXPAND: begin
                        // only bits inside the table are touched
                        for (int w = 0; w < `BSREU_WORDS; w++) begin
                            for (int j = 0; j < `BSREU_WORD_W; j++) begin
                                if (9'(w*16 + j) < tbl_len) begin
                                    mem_nxt[4'(instr_in.dst_word + 4'(w))][j] =
                                        (8'(w*16 + j) == exp_idx);
                                end
                            end
                        end
                    end
                    bsreu_pkg::BSREU_OP_ONES_TALLY: begin
                        mem_nxt[instr_in.dst_word] = {11'h000, tally_cnt};
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            for (int w = 0; w < `BSREU_WORDS; w++) begin
                mem_r[w] <= `BSREU_WORD_RST;
            end
            carry_r <= 1'b0;
            err_r <= 1'b0;
            rung_r <= 1'b0;
            done_r <= 1'b0;
            stat_r <= `BSREU_EV_RST;
            mask_r <= `BSREU_EV_RST;
            rdata_r <= `BSREU_ALL_ZERO;
        end else begin
            mem_r <= mem_nxt;
            carry_r <= carry_nxt;
            err_r <= err_nxt;
            rung_r <= rung_nxt;
            done_r <= done_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign bus_rdata_out = rdata_r;
    assign rung_out = rung_r;
    assign done_out = done_r;
    assign carry_flag_out = carry_r;
    assign instruction_error_flag_out = err_r;
    assign irq_out = |(stat_r & mask_r);

    // helper state seen only by the checks below
    bsreu_pkg::bsreu_instr_t h_instr_r;
    logic h_valid_r;
    logic h_found_r;
    logic h_bus_wr_r;
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            h_instr_r <= '0;
            h_valid_r <= 1'b0;
            h_found_r <= 1'b0;
            h_bus_wr_r <= 1'b0;
        end else begin
            h_instr_r <= instr_in;
            h_valid_r <= instr_valid_in;
            h_found_r <= found;
            h_bus_wr_r <= bus_in.wr;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    disabled_rung_low_a: assert property (
        instr_valid_in && !instr_in.enable |=> !rung_out && done_out)
        else $error("disabled instruction did not drive the output false");

    // back to back issue keeps done high, so compare against the last strobe
    done_pulse_a: assert property (
        done_out == $past(instr_valid_in))
        else $error("done pulse does not follow the issue strobe");

    fill_bit_one_a: assert property (
        h_valid_r && h_instr_r.enable && h_instr_r.op == bsreu_pkg::BSREU_OP_FILL
        && h_instr_r.bit_mode |-> mem_r[h_instr_r.dst_word][h_instr_r.dst_bit])
        else $error("fill of a bit left it zero");

    fill_word_ones_a: assert property (
        h_valid_r && h_instr_r.enable && h_instr_r.op == bsreu_pkg::BSREU_OP_FILL
        && !h_instr_r.bit_mode |-> mem_r[h_instr_r.dst_word] == `BSREU_ALL_ONES && rung_out)
        else $error("fill of a word did not give all ones");

    clear_bit_zero_a: assert property (
        h_valid_r && h_instr_r.enable && h_instr_r.op == bsreu_pkg::BSREU_OP_CLEAR
        && h_instr_r.bit_mode |-> !mem_r[h_instr_r.dst_word][h_instr_r.dst_bit])
        else $error("clear of a bit left it one");

    clear_word_zero_a: assert property (
        h_valid_r && h_instr_r.enable && h_instr_r.op == bsreu_pkg::BSREU_OP_CLEAR
        && !h_instr_r.bit_mode |-> mem_r[h_instr_r.dst_word] == `BSREU_ALL_ZERO)
        else $error("clear of a word did not give zero");

    carry_set_one_a: assert property (
        exec && instr_in.op == bsreu_pkg::BSREU_OP_CARRY_SET |=> carry_flag_out)
        else $error("carry set did not raise the carry flag");

    carry_clear_zero_a: assert property (
        exec && instr_in.op == bsreu_pkg::BSREU_OP_CARRY_CLEAR |=> !carry_flag_out)
        else $error("carry clear did not lower the carry flag");

    // disabled carry instructions fall under this one as well
    carry_hold_a: assert property (
        !bus_in.wr && !(exec && (instr_in.op == bsreu_pkg::BSREU_OP_CARRY_SET
        || instr_in.op == bsreu_pkg::BSREU_OP_CARRY_CLEAR)) |=> $stable(carry_flag_out))
        else $error("carry flag moved with no instruction");

    word_persist_a: assert property (
        (!instr_valid_in && !bus_in.wr) [*2] |-> $stable(mem_r[0]))
        else $error("stored word changed with no write");

    empty_find_err_a: assert property (
        h_valid_r && h_instr_r.enable && h_instr_r.op == bsreu_pkg::BSREU_OP_PRIORITY_FIND
        && !h_found_r |-> !rung_out && instruction_error_flag_out)
        else $error("empty table did not raise the error flag");

    find_result_a: assert property (
        h_valid_r && h_instr_r.enable && h_instr_r.op == bsreu_pkg::BSREU_OP_PRIORITY_FIND
        && h_instr_r.size_n >= `BSREU_N_MIN && h_instr_r.size_n <= `BSREU_N_MAX
        && h_found_r && !h_bus_wr_r |-> mem_r[h_instr_r.dst_word][15:8] == 8'h00 && rung_out)
        else $error("find result has nonzero upper bits");

    tally_range_a: assert property (
        h_valid_r && h_instr_r.enable && h_instr_r.op == bsreu_pkg::BSREU_OP_ONES_TALLY
        && TALLY_EN |-> mem_r[h_instr_r.dst_word] <= 16'h0010)
        else $error("tally result out of range");

    // only a new event or a mask write may raise the interrupt
    irq_level_a: assert property (
        $rose(irq_out) |-> $past(instr_valid_in) || $past(bus_in.wr))
        else $error("interrupt rose with no event and no mask write");

    rdata_idle_zero_a: assert property (
        !$past(bus_in.rd) |-> bus_rdata_out == `BSREU_ALL_ZERO)
        else $error("read data not zero outside the read answer cycle");
endmodule

// ===== tb/tb_bsreu_top.sv
// self-checking bench for the bit set, reset and encode unit
`timescale 1ns/1ns
module tb_bsreu_top;
    logic clk_in;
    logic rst_b_in;
    bsreu_pkg::bsreu_bus_req_t bus_in;
    logic [15:0] bus_rdata_out;
    logic instr_valid_in;
    bsreu_pkg::bsreu_instr_t instr_in;
    logic rung_out;
    logic done_out;
    logic carry_flag_out;
    logic instruction_error_flag_out;
    logic irq_out;
    int failures;
    int n_compared;

    bsreu_top #(.TALLY_EN(1'b1)) dut (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .bus_in(bus_in),
        .bus_rdata_out(bus_rdata_out),
        .instr_valid_in(instr_valid_in),
        .instr_in(instr_in),
        .rung_out(rung_out),
        .done_out(done_out),
        .carry_flag_out(carry_flag_out),
        .instruction_error_flag_out(instruction_error_flag_out),
        .irq_out(irq_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // trailing #1 lets registered effects settle before the caller looks
    task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus_in <= '0;
        #1;
    endtask

    task automatic rd_chk(input string what, input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus_in <= '0;
        #1;
        chk(what, bus_rdata_out, exp);
    endtask

    task automatic run(input bsreu_pkg::bsreu_op_t op, input logic en, input logic bm,
            input logic [3:0] dw, input logic [3:0] db, input logic [3:0] sw,
            input logic [3:0] n);
        @(posedge clk_in);
        instr_valid_in <= 1'b1;
        instr_in <= '{op: op, enable: en, bit_mode: bm, dst_word: dw, dst_bit: db,
            src_word: sw, size_n: n};
        @(posedge clk_in);
        instr_valid_in <= 1'b0;
        #1;
        chk("done", done_out, 16'h0001);
    endtask

    // no wait in the bench is open-ended; this cuts any hang short
    initial begin
        repeat (5000) @(posedge clk_in);
        failures++;
        test_done();
    end

    initial begin
        failures = 0;
        n_compared = 0;
        rst_b_in = 1'b0;
        bus_in = '0;
        instr_valid_in = 1'b0;
        instr_in = '0;
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        rd_chk("word0 reset", 5'h00, 16'h0000);
        rd_chk("flags reset", 5'h10, 16'h0000);
        rd_chk("unmapped", 5'h1F, 16'h0000);
        $display("test reset done");

        run(bsreu_pkg::BSREU_OP_FILL, 1'b1, 1'b0, 4'h2, 4'h0, 4'h0, 4'h1);
        chk("rung fill", rung_out, 16'h0001);
        rd_chk("word2 fill", 5'h02, 16'hFFFF);
        run(bsreu_pkg::BSREU_OP_CLEAR, 1'b1, 1'b1, 4'h2, 4'h5, 4'h0, 4'h1);
        rd_chk("word2 bit clear", 5'h02, 16'hFFDF);
        run(bsreu_pkg::BSREU_OP_FILL, 1'b1, 1'b1, 4'h3, 4'h5, 4'h0, 4'h1);
        rd_chk("word3 bit fill", 5'h03, 16'h0020);
        run(bsreu_pkg::BSREU_OP_CLEAR, 1'b0, 1'b0, 4'h2, 4'h0, 4'h0, 4'h1);
        chk("rung disabled", rung_out, 16'h0000);
        rd_chk("word2 kept", 5'h02, 16'hFFDF);
        run(bsreu_pkg::BSREU_OP_CLEAR, 1'b1, 1'b0, 4'h2, 4'h0, 4'h0, 4'h1);
        rd_chk("word2 clear", 5'h02, 16'h0000);
        $display("test fill clear done");

        run(bsreu_pkg::BSREU_OP_CARRY_SET, 1'b1, 1'b0, 4'h0, 4'h0, 4'h0, 4'h1);
        chk("carry set", carry_flag_out, 16'h0001);
        run(bsreu_pkg::BSREU_OP_CARRY_CLEAR, 1'b0, 1'b0, 4'h0, 4'h0, 4'h0, 4'h1);
        chk("carry held", carry_flag_out, 16'h0001);
        run(bsreu_pkg::BSREU_OP_CARRY_CLEAR, 1'b1, 1'b0, 4'h0, 4'h0, 4'h0, 4'h1);
        chk("carry clear", carry_flag_out, 16'h0000);
        run(bsreu_pkg::BSREU_OP_CARRY_SET, 1'b0, 1'b0, 4'h0, 4'h0, 4'h0, 4'h1);
        chk("carry idle", carry_flag_out, 16'h0000);
        run(bsreu_pkg::bsreu_op_t'(3'h7), 1'b1, 1'b0, 4'h0, 4'h0, 4'h0, 4'h1);
        chk("rung nop", rung_out, 16'h0001);
        chk("carry nop", carry_flag_out, 16'h0000);
        $display("test carry done");

        // highest one sits in the second word of a 32-bit table: index 24
        bus_wr(5'h04, 16'h0009);
        bus_wr(5'h05, 16'h0100);
        bus_wr(5'h06, 16'hABCD);
        run(bsreu_pkg::BSREU_OP_PRIORITY_FIND, 1'b1, 1'b0, 4'h6, 4'h0, 4'h4, 4'h5);
        chk("rung find", rung_out, 16'h0001);
        rd_chk("find index", 5'h06, 16'h0018);
        run(bsreu_pkg::BSREU_OP_PRIORITY_FIND, 1'b1, 1'b0, 4'h6, 4'h0, 4'h2, 4'h4);
        chk("rung empty", rung_out, 16'h0000);
        chk("error empty", instruction_error_flag_out, 16'h0001);
        rd_chk("find no write", 5'h06, 16'h0018);
        bus_wr(5'h10, 16'h0003);
        chk("error cleared", instruction_error_flag_out, 16'h0000);
        chk("carry written", carry_flag_out, 16'h0001);
        run(bsreu_pkg::BSREU_OP_PRIORITY_FIND, 1'b1, 1'b0, 4'h6, 4'h0, 4'h4, 4'h9);
        chk("rung size 9", rung_out, 16'h0000);
        chk("error size 9", instruction_error_flag_out, 16'h0001);
        rd_chk("flags after size 9", 5'h10, 16'h0003);
        $display("test find done");

        // index 19 lands on bit 3 of the second table word
        bus_wr(5'h08, 16'hFFFF);
        bus_wr(5'h09, 16'hFFFF);
        bus_wr(5'h07, 16'h00F3);
        run(bsreu_pkg::BSREU_OP_ONE_HOT_EXPAND, 1'b1, 1'b0, 4'h8, 4'h0, 4'h7, 4'h5);
        rd_chk("expand low", 5'h08, 16'h0000);
        rd_chk("expand high", 5'h09, 16'h0008);
        run(bsreu_pkg::BSREU_OP_ONE_HOT_EXPAND, 1'b1, 1'b0, 4'h8, 4'h0, 4'h7, 4'h0);
        chk("rung expand size 0", rung_out, 16'h0000);
        rd_chk("expand size 0 no write", 5'h09, 16'h0008);
        run(bsreu_pkg::BSREU_OP_ONES_TALLY, 1'b1, 1'b0, 4'hA, 4'h0, 4'h7, 4'h1);
        chk("rung tally", rung_out, 16'h0001);
        rd_chk("tally", 5'h0A, 16'h0006);
        $display("test expand tally done");

        rd_chk("int status", 5'h11, 16'h0003);
        chk("irq masked", irq_out, 16'h0000);
        bus_wr(5'h12, 16'h0001);
        chk("irq on", irq_out, 16'h0001);
        bus_wr(5'h11, 16'h0001);
        chk("irq cleared", irq_out, 16'h0000);
        rd_chk("int status left", 5'h11, 16'h0002);
        $display("test interrupt done");
        test_done();
    end
endmodule
